// ==== core/aif_pkg.sv ====
// Constants shared by the converter interrupt flag block
package aif_pkg;

    // ============================================================
    // Geometry
    localparam int NUM_LINES = 9;
    localparam int NUM_EOC   = 16;
    localparam int SEL_W     = 5;
    localparam int CFG_W     = 7;
    localparam int IDX_W     = 6;
    localparam int ADDR_W    = 8;

    // ============================================================
    // Register word indices (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h00;
    localparam logic [IDX_W-1:0] IDX_FLAGS    = 6'h04;
    localparam logic [IDX_W-1:0] IDX_FLAG_CLR = 6'h05;
    localparam logic [IDX_W-1:0] IDX_OVF      = 6'h06;
    localparam logic [IDX_W-1:0] IDX_OVF_CLR  = 6'h07;
    localparam logic [IDX_W-1:0] IDX_SEL_BASE = 6'h08;
    localparam logic [IDX_W-1:0] IDX_SEL_LAST = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h0e;

    // ============================================================
    // Field positions
    localparam int CTRL_PULSEPOS_BIT = 2;
    localparam int CFG_CONT_BIT      = 6;
    localparam int CFG_EN_BIT        = 5;
    localparam int SEL_HI_LSB        = 8;

    // ============================================================
    // Reset values
    localparam logic [NUM_LINES-1:0] LINES_RST = 9'h000;
    localparam logic [CFG_W-1:0]     CFG_RST   = 7'h00;
    localparam logic                 BIT_RST   = 1'b0;

    // ============================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ==== core/aif_reg_if.sv ====
// Register access carrier between bus slave and register file
`timescale 1ns/1ps
interface aif_reg_if;
    logic                         wr_en;
    logic [aif_pkg::IDX_W-1:0]    wr_idx;
    logic [31:0]                  wr_data;
    logic [3:0]                   wr_strb;
    logic                         wr_err;
    logic                         rd_en;
    logic [aif_pkg::IDX_W-1:0]    rd_idx;
    logic [31:0]                  rd_data;
    logic                         rd_err;

    modport master (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
                    input  wr_err, rd_data, rd_err);
    modport target (input  wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
                    output wr_err, rd_data, rd_err);
endinterface

// ==== core/aif_axil_slave.sv ====
// AXI4-Lite slave front end
`timescale 1ns/1ps
module aif_axil_slave (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [aif_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [aif_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    aif_reg_if.master                        regs
);
    logic                        aw_hold_reg;
    logic [aif_pkg::IDX_W-1:0]   aw_idx_reg;
    logic                        w_hold_reg;
    logic [31:0]                 w_data_reg;
    logic [3:0]                  w_strb_reg;

    // ============================================================
    // Register file strobes
    assign regs.wr_en   = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    assign regs.wr_idx  = aw_idx_reg;
    assign regs.wr_data = w_data_reg;
    assign regs.wr_strb = w_strb_reg;
    assign regs.rd_en   = s_axi_arvalid & s_axi_arready;
    assign regs.rd_idx  = s_axi_araddr[aif_pkg::ADDR_W-1:2];

    // ============================================================
    // Write address and data, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            aw_idx_reg    <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg   <= 1'b1;
            aw_idx_reg    <= s_axi_awaddr[aif_pkg::ADDR_W-1:2];
            s_axi_awready <= 1'b0;
        end else if (regs.wr_en) begin
            aw_hold_reg   <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg   <= 1'b0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (regs.wr_en) begin
            w_hold_reg   <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // ============================================================
    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= aif_pkg::RESP_OKAY;
        end else if (regs.wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= regs.wr_err ? aif_pkg::RESP_DECERR : aif_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ============================================================
    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= aif_pkg::RESP_OKAY;
        end else if (regs.rd_en) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= regs.rd_data;
            s_axi_rresp   <= regs.rd_err ? aif_pkg::RESP_DECERR : aif_pkg::RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule

// ==== core/aif_line_cell.sv ====
// One interrupt line: pulse, sticky flag and overflow capture
`timescale 1ns/1ps
module aif_line_cell (
    input  wire logic    aclk,
    input  wire logic    aresetn,
    input  wire logic    trig,
    input  wire logic    cont,
    input  wire logic    flag_clr,
    input  wire logic    ovf_clr,
    output logic         pulse_reg,
    output logic         flag_reg,
    output logic         ovf_reg
);
    logic pulse_next;
    logic ovf_set;

    // Re-pulse in continuous mode, else only while flag clear
    assign pulse_next = trig & (cont | ~flag_reg);
    // Overflow on a repeat trigger, untouched by a colliding clear
    assign ovf_set    = trig & flag_reg & ~flag_clr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= trig | (flag_reg & ~flag_clr);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= ovf_set | (ovf_reg & ~ovf_clr);
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_oneshot_hit;
        trig && !cont && flag_reg;
    endsequence
    sequence s_collide;
        trig && flag_clr;
    endsequence

    a_cont_repulse:  assert property (trig && cont |=> pulse_reg && flag_reg)
        else $error("continuous trigger gave no pulse");
    a_oneshot_block: assert property (s_oneshot_hit |=> !pulse_reg)
        else $error("one-shot line pulsed with flag set");
    a_ovf_record:    assert property (trig && flag_reg && !flag_clr |=> ovf_reg)
        else $error("overflow not recorded");
    a_flag_clear:    assert property (flag_clr && !trig |=> !flag_reg)
        else $error("flag clear ignored");
    a_set_wins:      assert property (s_collide |=> flag_reg)
        else $error("clear beat hardware set");
    a_ovf_untouched: assert property ((s_collide and !ovf_clr)
                                      |=> ovf_reg == $past(ovf_reg))
        else $error("collision changed overflow");
    a_ovf_set_wins:  assert property (ovf_clr && trig && flag_reg && !flag_clr
                                      |=> ovf_reg)
        else $error("overflow clear beat set");
    a_flag_sticky:   assert property (flag_reg && !flag_clr
                                      |=> flag_reg [*1] ##0 !$fell(flag_reg))
        else $error("flag dropped without clear");
    a_pulse_one:     assert property (pulse_reg && !trig |=> !pulse_reg)
        else $error("pulse wider than one cycle");
    a_pulse_flag:    assert property (pulse_reg |-> flag_reg)
        else $error("pulse without flag");

endmodule

// ==== core/aif_top.sv ====
// Converter interrupt flag, clear and overflow logic with AXI4-Lite registers
//
// Contract
// - Upper bits 15-9 of flag and flag-clear registers read zero, writes ignored.
// - Nine sticky flags in bits 8-0, set once that line pulses.
// - Continuous mode: every selected end-of-conversion event pulses, flag set or not.
// - Not continuous with flag set: no further pulses until software clears flag.
// - A suppressed pulse is recorded as that line's overflow.
// - Writing one to flag-clear clears the flag; zero leaves it.
// - Flag-clear at word 05h, bits 8-0 map lines 9-1, reset zero.
// - Same-cycle clear and hardware set: the set wins, flag stays set.
// - Same-cycle clear and set leaves the overflow bit unchanged.
// - Overflow status register sits at word 06h.
// - Overflow when flag set and another selected trigger arrives, any mode.
// - Writing one to overflow-clear clears overflow; reads zero; set wins.
// - Select words from 08h, two lines each: continuous, enable, 5-bit source.
// - Pulse timing selects conversion start or one cycle before result latch.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module aif_top (
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    input  wire logic [aif_pkg::ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [aif_pkg::ADDR_W-1:0]           s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [31:0]                               s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    input  wire logic [aif_pkg::NUM_EOC-1:0]          soc_start_evt,
    input  wire logic [aif_pkg::NUM_EOC-1:0]          result_latch_evt,
    output logic [aif_pkg::NUM_LINES-1:0]             conversion_irq_line,
    output logic                                      irq
);
    localparam int NL         = aif_pkg::NUM_LINES;
    localparam int IDX_LINE_W = 4;

    aif_reg_if regs ();

    logic                          pulse_timing_select_reg;
    logic [aif_pkg::CFG_W-1:0]     cfg_reg [NL];
    logic [NL-1:0]                 irq_stat_reg;
    logic [NL-1:0]                 irq_mask_reg;
    logic                          irq_reg;
    logic [NL-1:0]                 flags;
    logic [NL-1:0]                 ovfs;
    logic [NL-1:0]                 trig;
    logic [NL-1:0]                 flag_clr;
    logic [NL-1:0]                 ovf_clr;
    logic [NL-1:0]                 irq_stat_next;
    logic [aif_pkg::NUM_EOC-1:0]   evt;
    logic [31:0]                   wd;
    logic                          wr_sel;
    logic [IDX_LINE_W-1:0]         wr_pair;
    logic                          rd_sel;
    logic [IDX_LINE_W-1:0]         rd_pair;

    // ============================================================
    // Bus slave
    aif_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs.master)
    );

    // ============================================================
    // Write decode
    assign wd = regs.wr_data & {{8{regs.wr_strb[3]}}, {8{regs.wr_strb[2]}},
                                {8{regs.wr_strb[1]}}, {8{regs.wr_strb[0]}}};

    assign wr_sel  = regs.wr_en && regs.wr_idx >= aif_pkg::IDX_SEL_BASE
                     && regs.wr_idx <= aif_pkg::IDX_SEL_LAST;
    assign wr_pair = IDX_LINE_W'(regs.wr_idx - aif_pkg::IDX_SEL_BASE);

    // W1C strobes, bits above 8 dropped
    assign flag_clr = (regs.wr_en && regs.wr_idx == aif_pkg::IDX_FLAG_CLR)
                      ? wd[NL-1:0] : '0;
    assign ovf_clr  = (regs.wr_en && regs.wr_idx == aif_pkg::IDX_OVF_CLR)
                      ? wd[NL-1:0] : '0;

    always_comb begin
        regs.wr_err = 1'b0;
        case (regs.wr_idx)
            aif_pkg::IDX_CTRL, aif_pkg::IDX_FLAGS, aif_pkg::IDX_FLAG_CLR,
            aif_pkg::IDX_OVF, aif_pkg::IDX_OVF_CLR, aif_pkg::IDX_IRQ_STAT,
            aif_pkg::IDX_IRQ_MASK: begin
                regs.wr_err = 1'b0;
            end
            default: begin
                regs.wr_err = !wr_sel;
            end
        endcase
    end

    // ============================================================
    // Control and select registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_timing_select_reg <= aif_pkg::BIT_RST;
        end else if (regs.wr_en && regs.wr_idx == aif_pkg::IDX_CTRL
                     && regs.wr_strb[0]) begin
            pulse_timing_select_reg <= regs.wr_data[aif_pkg::CTRL_PULSEPOS_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NL; i++) begin
                cfg_reg[i] <= aif_pkg::CFG_RST;
            end
        end else if (wr_sel) begin
            for (int i = 0; i < NL; i++) begin
                if (i / 2 == int'(wr_pair) && i % 2 == 0 && regs.wr_strb[0]) begin
                    cfg_reg[i] <= regs.wr_data[aif_pkg::CFG_W-1:0];
                end
                if (i / 2 == int'(wr_pair) && i % 2 == 1 && regs.wr_strb[1]) begin
                    cfg_reg[i] <= regs.wr_data[aif_pkg::SEL_HI_LSB +: aif_pkg::CFG_W];
                end
            end
        end
    end

    // ============================================================
    // Trigger selection
    assign evt = pulse_timing_select_reg ? result_latch_evt : soc_start_evt;

    always_comb begin
        trig = '0;
        for (int i = 0; i < NL; i++) begin
            if (cfg_reg[i][aif_pkg::SEL_W-1:0] < aif_pkg::SEL_W'(aif_pkg::NUM_EOC)) begin
                trig[i] = cfg_reg[i][aif_pkg::CFG_EN_BIT]
                          & evt[cfg_reg[i][3:0]];
            end
        end
    end

    // ============================================================
    // Interrupt lines
    for (genvar g = 0; g < NL; g++) begin : g_line
        aif_line_cell u_cell (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .trig      (trig[g]),
            .cont      (cfg_reg[g][aif_pkg::CFG_CONT_BIT]),
            .flag_clr  (flag_clr[g]),
            .ovf_clr   (ovf_clr[g]),
            .pulse_reg (conversion_irq_line[g]),
            .flag_reg  (flags[g]),
            .ovf_reg   (ovfs[g])
        );
    end

    // ============================================================
    // Summary interrupt
    assign irq_stat_next = conversion_irq_line
                           | (irq_stat_reg & ~((regs.wr_en
                              && regs.wr_idx == aif_pkg::IDX_IRQ_STAT) ? wd[NL-1:0] : '0));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= aif_pkg::LINES_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= aif_pkg::LINES_RST;
        end else if (regs.wr_en && regs.wr_idx == aif_pkg::IDX_IRQ_MASK) begin
            irq_mask_reg <= (irq_mask_reg & ~{regs.wr_strb[1], {8{regs.wr_strb[0]}}})
                            | wd[NL-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    assign irq = irq_reg;

    // ============================================================
    // Read decode
    assign rd_sel  = regs.rd_idx >= aif_pkg::IDX_SEL_BASE
                     && regs.rd_idx <= aif_pkg::IDX_SEL_LAST;
    assign rd_pair = IDX_LINE_W'(regs.rd_idx - aif_pkg::IDX_SEL_BASE);

    always_comb begin
        regs.rd_data = '0;
        regs.rd_err  = 1'b0;
        case (regs.rd_idx)
            aif_pkg::IDX_CTRL: begin
                regs.rd_data[aif_pkg::CTRL_PULSEPOS_BIT] = pulse_timing_select_reg;
            end
            aif_pkg::IDX_FLAGS: begin
                regs.rd_data[NL-1:0] = flags;
            end
            aif_pkg::IDX_FLAG_CLR, aif_pkg::IDX_OVF_CLR: begin
                regs.rd_data = '0;
            end
            aif_pkg::IDX_OVF: begin
                regs.rd_data[NL-1:0] = ovfs;
            end
            aif_pkg::IDX_IRQ_STAT: begin
                regs.rd_data[NL-1:0] = irq_stat_reg;
            end
            aif_pkg::IDX_IRQ_MASK: begin
                regs.rd_data[NL-1:0] = irq_mask_reg;
            end
            default: begin
                regs.rd_err = !rd_sel;
                for (int i = 0; i < NL; i++) begin
                    if (rd_sel && i / 2 == int'(rd_pair)) begin
                        regs.rd_data[(i % 2) * aif_pkg::SEL_HI_LSB +: aif_pkg::CFG_W]
                            = cfg_reg[i];
                    end
                end
            end
        endcase
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_flag_rd_upper: assert property (
        regs.rd_en && regs.rd_idx == aif_pkg::IDX_FLAGS
        |=> s_axi_rdata[31:9] == '0 && s_axi_rvalid)
        else $error("flag read upper bits not zero");
    a_flag_clr_map:  assert property (
        regs.wr_en && regs.wr_idx == aif_pkg::IDX_FLAG_CLR && wd[0] && !trig[0]
        |=> !flags[0])
        else $error("clear bit 0 missed line one");
    a_ovf_rd_map:    assert property (
        regs.rd_en && regs.rd_idx == aif_pkg::IDX_OVF
        |=> s_axi_rdata[8:0] == $past(ovfs))
        else $error("overflow read mismatch");
    a_timing_pick:   assert property (
        pulse_timing_select_reg && cfg_reg[0][6:5] == 2'h3 && cfg_reg[0][4:0] == 5'h00
        && result_latch_evt[0] |=> conversion_irq_line[0])
        else $error("result-latch timing not honoured");

    // ============================================================
    // Register map checks
    a_clr_rd_zero:   assert property (
        regs.rd_en && regs.rd_idx == aif_pkg::IDX_FLAG_CLR
        |=> s_axi_rdata == '0)
        else $error("flag clear read not zero");
    a_flag_rd_map:   assert property (
        regs.rd_en && regs.rd_idx == aif_pkg::IDX_FLAGS
        |=> s_axi_rdata[8:0] == $past(flags))
        else $error("flag read mismatch");
    a_ovf_clr_map:   assert property (
        regs.wr_en && regs.wr_idx == aif_pkg::IDX_OVF_CLR && wd[0] && !(trig[0] && flags[0])
        |=> !ovfs[0])
        else $error("overflow clear missed line one");
    a_ovfclr_rd_zero: assert property (
        regs.rd_en && regs.rd_idx == aif_pkg::IDX_OVF_CLR
        |=> s_axi_rdata == '0)
        else $error("overflow clear read not zero");
    a_sel_low_wr:    assert property (
        wr_sel && wr_pair == 4'h0 && regs.wr_strb[0]
        |=> cfg_reg[0] == $past(regs.wr_data[6:0]))
        else $error("select low half not written");

endmodule

// ==== bench/aif_evt_src.sv ====
// Event source model standing in for the conversion sequencer
`timescale 1ns/1ps
module aif_evt_src (
    input  wire logic        aclk,
    input  wire logic        fire,
    input  wire logic        kind,
    input  wire logic [3:0]  src,
    output logic      [15:0] start_evt,
    output logic      [15:0] latch_evt
);
    always_ff @(posedge aclk) begin
        start_evt <= (fire && !kind) ? (16'h0001 << src) : 16'h0000;
        latch_evt <= (fire && kind) ? (16'h0001 << src) : 16'h0000;
    end
endmodule

// ==== bench/aif_top_bench.sv ====
// Self-checking bench for the converter interrupt flag block
`timescale 1ns/1ps
module aif_top_bench;
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready, fire, kind;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  src;
    logic [15:0] sevt, levt;
    logic [8:0]  line;
    int          errors = 0;
    int          cmp_count = 0;
    aif_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .soc_start_evt(sevt), .result_latch_evt(levt),
        .conversion_irq_line(line), .irq(irq));
    aif_evt_src evt (.aclk(aclk), .fire(fire), .kind(kind), .src(src),
        .start_evt(sevt), .latch_evt(levt));
    initial forever #10 aclk = ~aclk;
    // ==========
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        errors += int'(seen !== exp);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do begin
            @(negedge aclk);
            {ah, wh, bh, rs} = {awready & awvalid, wready & wvalid, bvalid, bresp};
            @(posedge aclk);
            {awvalid, wvalid} <= {awvalid & ~ah, wvalid & ~wh};
        end while (!bh);
        bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic ah, rh;
        logic [1:0] rr;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge aclk);
            {ah, rh, d, rr} = {arready & arvalid, rvalid, rdata, rresp};
            @(posedge aclk);
            arvalid <= arvalid & ~ah;
        end while (!rh);
        rready <= 1'b0;
        chk(d, exp);
        chk({30'h0, rr}, {30'h0, aif_pkg::RESP_OKAY});
    endtask
    task automatic pulse(input logic k, input logic [3:0] s, input logic [8:0] exp);
        @(posedge aclk);
        {fire, kind, src} <= {1'b1, k, s};
        @(posedge aclk);
        fire <= 1'b0;
        @(posedge aclk);
        #1 chk({23'h0, line}, {23'h0, exp});
        @(posedge aclk);
        #1 chk({23'h0, line}, 32'h0);
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        rchk(8'h14, 32'h0);
        rchk(8'h10, 32'h0);
        wr(8'hfc, 32'h1, r);
        chk({30'h0, r}, {30'h0, aif_pkg::RESP_DECERR});
    endtask
    task automatic t_oneshot;
        wr(8'h20, 32'h2423, r);
        wr(8'h38, 32'h1ff, r);
        pulse(1'b0, 4'h3, 9'h001);
        chk({31'h0, irq}, 32'h1);
        pulse(1'b0, 4'h3, 9'h000);
        rchk(8'h18, 32'h1);
        wr(8'h14, 32'hfffffe00, r);
        rchk(8'h10, 32'h1);
        wr(8'h14, 32'h1, r);
        rchk(8'h10, 32'h0);
        wr(8'h1c, 32'h1, r);
        rchk(8'h18, 32'h0);
        wr(8'h34, 32'h1ff, r);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_cont;
        wr(8'h20, 32'h2463, r);
        pulse(1'b0, 4'h3, 9'h001);
        pulse(1'b0, 4'h3, 9'h001);
        rchk(8'h18, 32'h1);
        wr(8'h00, 32'h4, r);
        pulse(1'b0, 4'h4, 9'h000);
        pulse(1'b1, 4'h4, 9'h002);
    endtask
    task automatic t_collide;
        wr(8'h1c, 32'h1ff, r);
        fork
            pulse(1'b1, 4'h3, 9'h001);
            wr(8'h14, 32'h1, r);
        join
        rchk(8'h10, 32'h3);
        rchk(8'h18, 32'h0);
        fork
            pulse(1'b1, 4'h3, 9'h001);
            wr(8'h1c, 32'h1, r);
        join
        rchk(8'h18, 32'h1);
    endtask
    initial begin
        repeat (4000) @(posedge aclk);
        errors++;
        wrap_up();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, kind} = 8'h00;
        {awaddr, araddr, wdata, src} = 52'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_oneshot();
        t_cont();
        t_collide();
        wrap_up();
    end
endmodule
